/* File: include/pmbr_regs.svh */
// Register offsets, field positions, reset values and counts for the
// port pin-sharing and bus-release block.
// Assumes one 32-bit AHB-Lite slave port; indices are scaled by four.
//
// Operation
// - Each low-port pin has a direction bit: 0 input, 1 output.
// - Reset clears low-port latch and direction, all pins inputs.
// - External access makes low port carry bus and clears direction.
// - Reading the data register returns pin levels; latch resets zero.
// - While released, bus, address, strobe and select drivers float.
// - Pull-up settings are frozen for the whole release.
// - Pull-ups are software-switchable only while the pin is input.
// - Address/data pins in port mode keep driving; bus mode floats.
// - Upper address and strobes go high first, then float.
// - Function-mode selects, write-high and direction pins float with pull-up forced on.
// - Registers inaccessible while released; peripherals keep running.
// - Reset: strobes outputs; selects, write-high, acknowledge pulled up.
// - Two-bit drain field selects open-drain for serial pins.
// - Slow oscillator pins as outputs drive open-drain.
`ifndef PMBR_REGS_SVH
`define PMBR_REGS_SVH

// Register indices; byte address is index times four
`define PMBR_IDX_DATA 16'h0000
`define PMBR_IDX_DIR 16'h0002
`define PMBR_IDX_FUNC 16'h0004
`define PMBR_IDX_PULLUP 16'h0005
`define PMBR_IDX_DRAIN 16'h0006
`define PMBR_IDX_OSC 16'h0007
`define PMBR_IDX_STATUS 16'h0008

// Reset values
`define PMBR_LATCH_RST 8'h00
`define PMBR_DIR_RST 8'h00
`define PMBR_FUNC_RST 8'h00
`define PMBR_PULLUP_RST 7'h7F
`define PMBR_DRAIN_RST 2'h0
`define PMBR_OSC_RST 2'h0

// Function register fields
`define PMBR_FN_HBW 0
`define PMBR_FN_RW 1
`define PMBR_FN_CS_LO 2
`define PMBR_FN_ADDR 6
`define PMBR_FN_ACK 7

// Pull-up register fields
`define PMBR_PU_HBW 0
`define PMBR_PU_CS_LO 1
`define PMBR_PU_ACK 5
`define PMBR_PU_RW 6

// Oscillator register fields
`define PMBR_OSC_DIR_LO 2

// Status register fields
`define PMBR_ST_RELEASED 0
`define PMBR_ST_LOW_FN 1

// Cycles spent driving high before floating
`define PMBR_PRECHARGE_CYCLES 2'h1

`endif

/* File: include/pmbr_pkg.sv */
// Types for the port pin-sharing and bus-release block.
// Assumes the constants header is on the include path.
`include "pmbr_regs.svh"
package pmbr_pkg;

   // AHB-Lite slave inputs
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } pmbr_ahb_req_t;

   // AHB-Lite slave answer
   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } pmbr_ahb_rsp_t;

   // Core side of the external bus
   typedef struct packed {
      logic access;
      logic [7:0] ad_out;
      logic ad_oe;
      logic [7:0] addr_hi;
      logic rd_n;
      logic wr_n;
      logic hbw_n;
      logic rw;
      logic [3:0] cs_n;
   } pmbr_core_bus_t;

   // Eight-pin group drive
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pmbr_pin8_t;

   // Two-pin group drive
   typedef struct packed {
      logic [1:0] out;
      logic [1:0] oe;
   } pmbr_pin2_t;

   // Control and strobe pins
   typedef struct packed {
      logic [7:0] addr_hi_out;
      logic [7:0] addr_hi_oe;
      logic rd_n;
      logic rd_oe;
      logic wr_n;
      logic wr_oe;
      logic high_byte_write_strobe_n;
      logic hbw_oe;
      logic hbw_pu;
      logic rw;
      logic rw_oe;
      logic rw_pu;
      logic [3:0] cs_n;
      logic [3:0] cs_oe;
      logic [3:0] cs_pu;
      logic release_acknowledge_n;
      logic ack_oe;
      logic ack_pu;
   } pmbr_ctrl_pins_t;

   // Release sequencer states
   typedef enum logic [1:0] {
      PMBR_RS_IDLE = 2'b00,
      PMBR_RS_PRECHARGE = 2'b01,
      PMBR_RS_HELD = 2'b10
   } pmbr_rel_state_t;

endpackage

/* File: verilog/pmbr_release_seq.sv */
// Bus-release sequencer: precharge the strobes, then hold the bus off.
// Assumes release_request is synchronous and the core stops accesses.
`timescale 1ns/100ps
`default_nettype none
`include "pmbr_regs.svh"
module pmbr_release_seq (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Request side
   input wire logic release_request,
   input wire logic enable,
   input wire logic ext_busy,
   // State to the pin logic
   output var logic precharge,
   output var logic released
);
   import pmbr_pkg::*;

   pmbr_rel_state_t state_r;
   pmbr_rel_state_t state_nxt;
   logic [1:0] cnt_r;

   // Release only between external accesses
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         PMBR_RS_IDLE: begin
            if (release_request && enable && !ext_busy) begin
               state_nxt = PMBR_RS_PRECHARGE;
            end
         end
         PMBR_RS_PRECHARGE: begin
            if (cnt_r == `PMBR_PRECHARGE_CYCLES) begin
               state_nxt = PMBR_RS_HELD;
            end
         end
         PMBR_RS_HELD: begin
            if (!release_request) begin
               state_nxt = PMBR_RS_IDLE;
            end
         end
         default: state_nxt = PMBR_RS_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_r <= PMBR_RS_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Precharge length counter
   always_ff @(posedge clock) begin
      if (!reset_n || state_r != PMBR_RS_PRECHARGE) begin
         cnt_r <= 2'h1;
      end else begin
         cnt_r <= cnt_r + 2'h1;
      end
   end

   assign precharge = (state_r == PMBR_RS_PRECHARGE);
   assign released = (state_r == PMBR_RS_HELD);

endmodule
`default_nettype wire

/* File: verilog/pmbr_top.sv */
// Pin-sharing logic for the low multiplexed port, control strobes,
// serial and oscillator pins, with external bus release.
// Assumes AHB-Lite with a single master and all pins synchronous.
`timescale 1ns/100ps
`default_nettype none
`include "pmbr_regs.svh"
module pmbr_top (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Register bus
   input wire pmbr_pkg::pmbr_ahb_req_t ahb_req,
   output var pmbr_pkg::pmbr_ahb_rsp_t ahb_rsp,
   // Core external bus
   input wire pmbr_pkg::pmbr_core_bus_t core_bus,
   output var logic [7:0] core_ad_in,
   // Bus release
   input wire logic release_request,
   output var logic bus_released,
   // Low port pins
   input wire logic [7:0] low_pin_in,
   output var pmbr_pkg::pmbr_pin8_t low_pin,
   // Control and strobe pins
   output var pmbr_pkg::pmbr_ctrl_pins_t ctrl_pins,
   // Serial data and clock pins
   input wire logic [1:0] ser_out,
   input wire logic [1:0] ser_oe_req,
   output var pmbr_pkg::pmbr_pin2_t ser_pin,
   // Slow oscillator pins
   input wire logic [1:0] osc_pin_in,
   output var pmbr_pkg::pmbr_pin2_t osc_pin
);
   import pmbr_pkg::*;

   logic [7:0] low_port_latch_r;
   logic [7:0] low_port_direction_r;
   logic low_fn_r;
   logic [7:0] func_r;
   logic [6:0] pullup_r;
   logic [1:0] open_drain_pair_select_r;
   logic [1:0] osc_latch_r;
   logic [1:0] osc_dir_r;
   logic wr_pend_r;
   logic [15:0] wr_idx_r;
   logic precharge;
   logic released;
   logic ext_access;
   logic addr_ok;
   logic [15:0] req_idx;
   logic req_valid;
   logic wr_go;
   logic [31:0] rdata_nxt;
   logic [6:0] pu_input_mask;
   pmbr_pin8_t low_pin_nxt;
   pmbr_ctrl_pins_t ctrl_nxt;
   pmbr_pin2_t ser_nxt;
   pmbr_pin2_t osc_nxt;

   // Release sequencer
   pmbr_release_seq u_release (
      .clock(clock),
      .reset_n(reset_n),
      .release_request(release_request),
      .enable(func_r[`PMBR_FN_ACK]),
      .ext_busy(core_bus.access),
      .precharge(precharge),
      .released(released)
   );

   // Core accesses are ignored once the bus is off
   assign ext_access = core_bus.access && !precharge && !released;

   // Address decode; upper bits and byte offset must be zero
   assign req_idx = ahb_req.haddr[17:2];
   assign addr_ok = (ahb_req.haddr[31:18] == 14'h0000) &&
      (ahb_req.haddr[1:0] == 2'h0);
   assign req_valid = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
   // Writes land in the data phase; nothing lands while released
   assign wr_go = wr_pend_r && ahb_req.hready && !released;

   // Address phase capture for writes
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         wr_pend_r <= 1'b0;
         wr_idx_r <= 16'h0000;
      end else if (ahb_req.hready) begin
         wr_pend_r <= req_valid && ahb_req.hwrite && addr_ok;
         wr_idx_r <= req_idx;
      end
   end

   // Read mux, sampled in the address phase
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (req_valid && !ahb_req.hwrite && addr_ok && !released) begin
         case (req_idx)
            `PMBR_IDX_DATA: rdata_nxt = {24'h000000, low_pin_in};
            `PMBR_IDX_DIR: rdata_nxt = 32'h0000_0000;
            `PMBR_IDX_FUNC: rdata_nxt = {24'h000000, func_r};
            `PMBR_IDX_PULLUP: rdata_nxt = {25'h0000000, pullup_r};
            `PMBR_IDX_DRAIN:
               rdata_nxt = {30'h00000000, open_drain_pair_select_r};
            `PMBR_IDX_OSC:
               rdata_nxt = {28'h0000000, osc_dir_r, osc_pin_in};
            `PMBR_IDX_STATUS:
               rdata_nxt = {30'h00000000, low_fn_r, released};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // Bus answer: zero wait, always OKAY
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ahb_rsp <= '{hreadyout: 1'b1, hresp: 1'b0, hrdata: 32'h0000_0000};
      end else begin
         ahb_rsp.hreadyout <= 1'b1;
         ahb_rsp.hresp <= 1'b0;
         if (ahb_req.hready) begin
            ahb_rsp.hrdata <= rdata_nxt;
         end
      end
   end

   // Low port output latch
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         low_port_latch_r <= `PMBR_LATCH_RST;
      end else if (wr_go && wr_idx_r == `PMBR_IDX_DATA) begin
         low_port_latch_r <= ahb_req.hwdata[7:0];
      end
   end

   // Direction bits; an external access clears them over a write
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         low_port_direction_r <= `PMBR_DIR_RST;
      end else if (ext_access) begin
         low_port_direction_r <= 8'h00;
      end else if (wr_go && wr_idx_r == `PMBR_IDX_DIR) begin
         low_port_direction_r <= ahb_req.hwdata[7:0];
      end
   end

   // Bus-function flag: stays until software claims a pin as output
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         low_fn_r <= 1'b0;
      end else if (ext_access) begin
         low_fn_r <= 1'b1;
      end else if (wr_go && wr_idx_r == `PMBR_IDX_DIR &&
            ahb_req.hwdata[7:0] != 8'h00) begin
         low_fn_r <= 1'b0;
      end
   end

   // Function, drain and oscillator registers
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         func_r <= `PMBR_FUNC_RST;
         open_drain_pair_select_r <= `PMBR_DRAIN_RST;
         osc_latch_r <= `PMBR_OSC_RST;
         osc_dir_r <= `PMBR_OSC_RST;
      end else if (wr_go) begin
         if (wr_idx_r == `PMBR_IDX_FUNC) begin
            func_r <= ahb_req.hwdata[7:0];
         end
         if (wr_idx_r == `PMBR_IDX_DRAIN) begin
            open_drain_pair_select_r <= ahb_req.hwdata[1:0];
         end
         if (wr_idx_r == `PMBR_IDX_OSC) begin
            osc_latch_r <= ahb_req.hwdata[1:0];
            osc_dir_r <= ahb_req.hwdata[`PMBR_OSC_DIR_LO +: 2];
         end
      end
   end

   // Only bits of pins in input mode accept a new pull-up setting
   assign pu_input_mask = {~func_r[`PMBR_FN_RW], ~func_r[`PMBR_FN_ACK],
      ~func_r[`PMBR_FN_CS_LO +: 4], ~func_r[`PMBR_FN_HBW]};

   // Pull-up settings; frozen while released since writes are blocked
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         pullup_r <= `PMBR_PULLUP_RST;
      end else if (wr_go && wr_idx_r == `PMBR_IDX_PULLUP) begin
         pullup_r <= (ahb_req.hwdata[6:0] & pu_input_mask) |
            (pullup_r & ~pu_input_mask);
      end
   end

   // Low port drive, one bit at a time
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_low
         always_comb begin
            if (ext_access) begin
               low_pin_nxt.out[gi] = core_bus.ad_out[gi];
               low_pin_nxt.oe[gi] = core_bus.ad_oe;
            end else if ((released || precharge) && low_fn_r) begin
               low_pin_nxt.out[gi] = low_port_latch_r[gi];
               low_pin_nxt.oe[gi] = 1'b0;
            end else begin
               // Port mode keeps driving through a release
               low_pin_nxt.out[gi] = low_port_latch_r[gi];
               low_pin_nxt.oe[gi] = low_port_direction_r[gi];
            end
         end
      end
   endgenerate

   // Control pins: strobes and upper address precharge high, then float; selects, write-high and direction held up by pull-ups
   always_comb begin
      ctrl_nxt = ctrl_pins;
      ctrl_nxt.hbw_pu = pullup_r[`PMBR_PU_HBW];
      ctrl_nxt.rw_pu = pullup_r[`PMBR_PU_RW];
      ctrl_nxt.cs_pu = pullup_r[`PMBR_PU_CS_LO +: 4];
      ctrl_nxt.ack_pu = pullup_r[`PMBR_PU_ACK];
      // Strobes are always outputs outside a release
      ctrl_nxt.rd_n = precharge ? 1'b1 : core_bus.rd_n;
      ctrl_nxt.wr_n = precharge ? 1'b1 : core_bus.wr_n;
      ctrl_nxt.rd_oe = !released;
      ctrl_nxt.wr_oe = !released;
      // Upper address lines
      ctrl_nxt.addr_hi_out = precharge ? 8'hFF : core_bus.addr_hi;
      ctrl_nxt.addr_hi_oe = {8{func_r[`PMBR_FN_ADDR] && !released}};
      // High-byte write strobe
      ctrl_nxt.high_byte_write_strobe_n = core_bus.hbw_n;
      ctrl_nxt.hbw_oe = func_r[`PMBR_FN_HBW] && !released;
      // Direction strobe
      ctrl_nxt.rw = core_bus.rw;
      ctrl_nxt.rw_oe = func_r[`PMBR_FN_RW] && !released;
      // Chip selects
      ctrl_nxt.cs_n = core_bus.cs_n;
      ctrl_nxt.cs_oe = func_r[`PMBR_FN_CS_LO +: 4] & {4{!released}};
      if (released) begin
         // Function pins lose drive but are held up by pull-ups
         if (func_r[`PMBR_FN_HBW]) begin
            ctrl_nxt.hbw_pu = 1'b1;
         end
         if (func_r[`PMBR_FN_RW]) begin
            ctrl_nxt.rw_pu = 1'b1;
         end
         ctrl_nxt.cs_pu = ctrl_nxt.cs_pu | func_r[`PMBR_FN_CS_LO +: 4];
      end
      // Release acknowledge, low while the bus is off
      ctrl_nxt.release_acknowledge_n = !released;
      ctrl_nxt.ack_oe = func_r[`PMBR_FN_ACK];
   end

   // Serial pins: open-drain drives only low
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (open_drain_pair_select_r[i]) begin
            ser_nxt.out[i] = 1'b0;
            ser_nxt.oe[i] = ser_oe_req[i] && !ser_out[i];
         end else begin
            ser_nxt.out[i] = ser_out[i];
            ser_nxt.oe[i] = ser_oe_req[i];
         end
      end
   end

   // Oscillator pins are open-drain whenever they are outputs
   always_comb begin
      osc_nxt.out = 2'h0;
      osc_nxt.oe = osc_dir_r & ~osc_latch_r;
   end

   // Pin output registers
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         low_pin <= '{out: 8'h00, oe: 8'h00};
         ctrl_pins <= '{addr_hi_out: 8'hFF, addr_hi_oe: 8'h00,
            rd_n: 1'b1, rd_oe: 1'b1, wr_n: 1'b1, wr_oe: 1'b1,
            high_byte_write_strobe_n: 1'b1, hbw_oe: 1'b0, hbw_pu: 1'b1,
            rw: 1'b1, rw_oe: 1'b0, rw_pu: 1'b1,
            cs_n: 4'hF, cs_oe: 4'h0, cs_pu: 4'hF,
            release_acknowledge_n: 1'b1, ack_oe: 1'b0,
            ack_pu: 1'b1};
         ser_pin <= '{out: 2'h0, oe: 2'h0};
         osc_pin <= '{out: 2'h0, oe: 2'h0};
      end else begin
         low_pin <= low_pin_nxt;
         ctrl_pins <= ctrl_nxt;
         ser_pin <= ser_nxt;
         osc_pin <= osc_nxt;
      end
   end

   // Core-side read data and release status
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         core_ad_in <= 8'h00;
         bus_released <= 1'b0;
      end else begin
         core_ad_in <= low_pin_in;
         bus_released <= released || precharge;
      end
   end

endmodule
`default_nettype wire

/* File: verif/pmbr_chk.sv */
// Checker for the port pin-sharing block, seeing only top-level ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module pmbr_chk (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Register bus
   input wire pmbr_pkg::pmbr_ahb_req_t ahb_req,
   input wire pmbr_pkg::pmbr_ahb_rsp_t ahb_rsp,
   // External bus and pins
   input wire pmbr_pkg::pmbr_core_bus_t core_bus,
   input wire logic release_request,
   input wire logic bus_released,
   input wire logic [7:0] low_pin_in,
   input wire pmbr_pkg::pmbr_pin8_t low_pin,
   input wire pmbr_pkg::pmbr_ctrl_pins_t ctrl_pins,
   input wire pmbr_pkg::pmbr_pin2_t osc_pin
);
   import pmbr_pkg::*;
   logic take;
   logic wr_ph_r;
   assign take = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
   // A write data phase in flight may retarget the pins
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         wr_ph_r <= 1'b0;
      end else begin
         wr_ph_r <= take & ahb_req.hwrite;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Release steps: strobes high, then strobe and upper address drivers off
   sequence s_pre;
      ctrl_pins.rd_n && ctrl_pins.wr_n && ctrl_pins.rd_oe &&
         ctrl_pins.wr_oe && ctrl_pins.addr_hi_out == 8'hFF;
   endsequence
   sequence s_off;
      !ctrl_pins.release_acknowledge_n && !ctrl_pins.rd_oe &&
         !ctrl_pins.wr_oe && ctrl_pins.addr_hi_oe == 8'h00;
   endsequence
   // Pins follow the direction register one edge after it is written
   sequence s_dirw;
      take && ahb_req.hwrite && ahb_req.haddr == 32'h8 && !bus_released &&
         !release_request ##1 !core_bus.access && !release_request &&
         !bus_released ##1 !core_bus.access && !bus_released;
   endsequence
   a_reset_low: assert property (disable iff (1'b0)
      !reset_n |=> low_pin.oe == 8'h00 && low_pin.out == 8'h00)
      else $error("low port not idle after reset");
   a_reset_ctrl: assert property (disable iff (1'b0)
      !reset_n |=> ctrl_pins.rd_oe && ctrl_pins.wr_oe && !ctrl_pins.hbw_oe
      && ctrl_pins.hbw_pu && ctrl_pins.cs_oe == 4'h0 &&
      ctrl_pins.cs_pu == 4'hF && !ctrl_pins.ack_oe && ctrl_pins.ack_pu)
      else $error("control pins wrong after reset");
   a_ext_take: assert property (
      core_bus.access && !bus_released && !release_request |=>
      low_pin.out == $past(core_bus.ad_out) &&
      low_pin.oe == {8{$past(core_bus.ad_oe)}})
      else $error("low port did not carry the bus");
   a_ext_clear: assert property (
      $fell(core_bus.access) && !bus_released && !release_request &&
      !wr_ph_r |=> low_pin.oe == 8'h00)
      else $error("direction not cleared after access");
   a_dir_write: assert property (
      s_dirw |=> low_pin.oe == $past(ahb_req.hwdata[7:0], 2))
      else $error("direction write not seen on pins");
   a_rel_steps: assert property (
      $rose(bus_released) |-> s_pre ##1 s_off)
      else $error("release did not precharge then float");
   a_rel_float: assert property (
      !ctrl_pins.release_acknowledge_n |-> !ctrl_pins.hbw_oe &&
      !ctrl_pins.rw_oe && ctrl_pins.cs_oe == 4'h0 && !ctrl_pins.rd_oe)
      else $error("driver on while released");
   a_pu_frozen: assert property (
      !ctrl_pins.release_acknowledge_n &&
      $past(!ctrl_pins.release_acknowledge_n) |->
      $stable(ctrl_pins.cs_pu) && $stable(ctrl_pins.hbw_pu) &&
      $stable(ctrl_pins.rw_pu))
      else $error("pull-up changed while released");
   a_pin_read: assert property (
      take && !ahb_req.hwrite && ahb_req.haddr == 32'h0 && !bus_released
      |=> ahb_rsp.hrdata == {24'h0, $past(low_pin_in)})
      else $error("data read is not the pin levels");
   a_rel_read: assert property (
      take && !ahb_req.hwrite && release_request &&
      !ctrl_pins.release_acknowledge_n |=> ahb_rsp.hrdata == 32'h0)
      else $error("register readable while released");
   a_osc_drain: assert property (
      osc_pin.oe != 2'b00 |-> osc_pin.out == 2'b00)
      else $error("oscillator pin drives high");
endmodule
bind pmbr_top pmbr_chk u_chk (.clock, .reset_n, .ahb_req, .ahb_rsp,
   .core_bus, .release_request, .bus_released, .low_pin_in, .low_pin,
   .ctrl_pins, .osc_pin);
`default_nettype wire

/* File: verif/pmbr_ext_model.sv */
// Far side: memory on the low pins and a second master wanting the bus.
// Assumes the low port has no pull-ups, so undriven lines wander.
`timescale 1ns/100ps
`default_nettype none
module pmbr_ext_model (
   // Clock
   input wire logic clock,
   // Low port wire
   input wire pmbr_pkg::pmbr_pin8_t low_pin,
   output var logic [7:0] low_pin_in,
   // Memory drive set by the bench
   input wire logic mem_drive,
   input wire logic [7:0] mem_data,
   // Second master
   input wire logic want_bus,
   input wire logic release_acknowledge_n,
   output var logic release_request,
   output var logic granted
);
   import pmbr_pkg::*;
   logic [7:0] idle_r = 8'h00;
   logic [7:0] far_lvl;
   // Undriven bits toggle each cycle unless memory drives, so no stale level is read
   always_comb begin
      far_lvl = mem_drive ? mem_data : idle_r;
      low_pin_in = (low_pin.out & low_pin.oe) | (far_lvl & ~low_pin.oe);
      release_request = want_bus;
      granted = want_bus & ~release_acknowledge_n;
   end
   always @(posedge clock) begin
      idle_r <= ~low_pin_in;
   end
endmodule
`default_nettype wire

/* File: verif/test_port_mux_bus_release.sv */
// Self-checking bench for the port pin-sharing block.
// Assumes the checker is bound in and the far-side model is compiled.
`timescale 1ns/100ps
`default_nettype none
module test_port_mux_bus_release;
   import pmbr_pkg::*;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic sel = 1'b0;
   logic wr = 1'b0;
   logic [1:0] trans = 2'b00;
   logic [31:0] addr = 32'h0;
   logic [31:0] wdata = 32'h0;
   pmbr_ahb_rsp_t rsp;
   pmbr_core_bus_t cb = '1;
   logic [7:0] pin_in;
   logic [7:0] mem_data = 8'h00;
   logic mem_drive = 1'b0;
   logic want = 1'b0;
   logic rel, granted, busr;
   logic [1:0] so = 2'b00;
   logic [1:0] soe = 2'b00;
   pmbr_pin8_t lp;
   pmbr_ctrl_pins_t cp;
   pmbr_pin2_t sp, op;
   int mismatches = 0;
   int n_tests = 0;
   logic [31:0] seed = 32'hD39A;
   logic [31:0] q, r;
   logic [7:0] d, v, m, adi;

   pmbr_top dut (.clock, .reset_n,
      .ahb_req(pmbr_ahb_req_t'({sel, addr, trans, wr, 3'b010, wdata,
         rsp.hreadyout})),
      .ahb_rsp(rsp), .core_bus(cb), .core_ad_in(adi), .release_request(rel),
      .bus_released(busr), .low_pin_in(pin_in), .low_pin(lp),
      .ctrl_pins(cp), .ser_out(so), .ser_oe_req(soe), .ser_pin(sp),
      .osc_pin_in(2'b00), .osc_pin(op));
   pmbr_ext_model ext (.clock, .low_pin(lp), .low_pin_in(pin_in),
      .mem_drive, .mem_data, .want_bus(want),
      .release_acknowledge_n(cp.release_acknowledge_n),
      .release_request(rel), .granted);

   // Clock at 25 MHz
   initial begin
      forever #20 clock = ~clock;
   end

   // Random stimulus and expected values
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] mix(input logic [7:0] a, b, c);
      return (a & b) | (c & ~b);
   endfunction
   function automatic logic [1:0] od(input logic [1:0] e, o, s);
      return e & ~(s & o);
   endfunction

   task automatic chk(input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One single transfer; waits on hready, no cycle count assumed
   task automatic bus(input logic w, input logic [31:0] a, dw);
      sel <= 1'b1;
      addr <= a;
      trans <= 2'b10;
      wr <= w;
      do @(posedge clock); while (rsp.hreadyout !== 1'b1);
      trans <= 2'b00;
      wdata <= dw;
      do @(posedge clock); while (rsp.hreadyout !== 1'b1);
      q = rsp.hrdata;
   endtask
   task automatic settle();
      @(posedge clock);
      #1;
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Watchdog at 20000 cycles, far beyond the couple of hundred the run needs
   initial begin
      #(40 * 20000);
      mismatches++;
      finish_test();
   end

   initial begin
      cb.access = 1'b0;
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      settle();
      chk(32'(lp), 32'h0);
      chk(32'({cp.rd_oe, cp.wr_oe, cp.hbw_oe, cp.hbw_pu, cp.cs_oe,
         cp.cs_pu, cp.ack_oe, cp.ack_pu}), 32'h343D);
      bus(1'b0, 32'h8, 32'h0);
      chk(q, 32'h0);
      // Random latch; direction all-output, all-input, then random; memory driving the input bits
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : r[7:0];
         v = r[15:8];
         m = r[23:16];
         mem_data <= m;
         mem_drive <= 1'b1;
         bus(1'b1, 32'h0, {24'h0, v});
         bus(1'b1, 32'h8, {24'h0, d});
         settle();
         chk(32'(lp), {16'h0, v, d});
         bus(1'b0, 32'h0, 32'h0);
         chk(q, {24'h0, mix(v, d, m)});
         chk(32'(adi), {24'h0, mix(v, d, m)});
      end
      mem_drive <= 1'b0;
      bus(1'b1, 32'h10, 32'hC3);
      bus(1'b1, 32'h14, 32'h0);
      settle();
      chk(32'({cp.hbw_pu, cp.rw_pu, cp.cs_pu, cp.ack_pu}), 32'h61);
      // Release once in bus function, once in port mode
      for (int k = 0; k < 2; k++) begin
         if (k == 0) begin
            r = rnd();
            cb.ad_out <= r[7:0];
            cb.ad_oe <= 1'b1;
            cb.access <= 1'b1;
            settle();
            settle();
            chk(32'(lp), {16'h0, r[7:0], 8'hFF});
            cb.access <= 1'b0;
            settle();
            settle();
            chk(32'(lp.oe), 32'h0);
         end else begin
            bus(1'b1, 32'h0, 32'hA5);
            bus(1'b1, 32'h8, 32'h5A);
         end
         want <= 1'b1;
         r = 0;
         do begin
            settle();
            r++;
         end while (granted !== 1'b1 && r < 10);
         chk(32'(granted), 32'h1);
         chk(32'(busr), 32'h1);
         // Bus mode floats the pins but the latch still sits behind them
         chk(32'(lp), (k == 0) ? {16'h0, v, 8'h00} : 32'hA55A);
         chk(32'({cp.hbw_oe, cp.rw_oe, cp.cs_oe, cp.rd_oe, cp.wr_oe,
            cp.addr_hi_oe}), 32'h0);
         chk(32'({cp.hbw_pu, cp.rw_pu, cp.cs_pu}), 32'h30);
         bus(1'b1, 32'h14, 32'h7F);
         settle();
         chk(32'(cp.cs_pu), 32'h0);
         bus(1'b0, 32'h0, 32'h0);
         chk(q, 32'h0);
         want <= 1'b0;
         repeat (4) settle();
      end
      // Serial pins under each drain setting
      for (int k = 0; k < 4; k++) begin
         r = rnd();
         so <= r[1:0];
         soe <= r[3:2];
         bus(1'b1, 32'h18, k);
         settle();
         chk(32'(sp.oe), 32'(od(r[3:2], r[1:0], k[1:0])));
         chk(32'(sp.out), 32'(r[1:0] & ~k[1:0]));
      end
      // Oscillator pins as outputs sink only
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, 32'h1C, {28'h0, 2'b11, k[1:0]});
         settle();
         chk(32'(op), {30'h0, ~k[1:0]});
      end
      finish_test();
   end
endmodule
`default_nettype wire
